/* rtl/cid_pkg.sv */
// Notes on behaviour
// RULE1: tone output only while select bit 7 set
// RULE2: select bits 3..0 choose the tone digit
// RULE3: guard time is bits 6..0 of guard register
// RULE4: mark period start sets event bit 6
// RULE5: progress tone status change sets event bit 5
// RULE6: new received frame sets event bit 2
// RULE7: alert tone detection sets event bit 1
// RULE8: reversal guard status change sets event bit 0
// RULE9: status bit 5 follows progress tone detector
// RULE10: status bit 1 follows alert tone detector
// RULE11: status bit 0 one after reset/expiry, else zero
// RULE12: received byte register holds last frame byte
// RULE13: tone output multiplied by gain register value
// RULE14: host writes fixed patterns to special registers
// RULE15: select 02H and guard 0AH are read/write
// RULE16: event, status, byte at 80H-82H read-only
// RULE17: acknowledge only serial address 30H/31H
// RULE18: store register address, advance on acknowledge
// RULE19: reading event register clears all flags
// RULE20: interrupt low while any event flag set
// RULE21: writes to read-only registers are ignored
// RULE22: reserved bits and unmapped addresses read zero
package cid_pkg;

  // serial device address, seven bits
  localparam logic [6:0] DEV_ADDR = 7'h18;

  // register offsets
  localparam logic [7:0] OFF_TONE_GAIN = 8'h00;
  localparam logic [7:0] OFF_TONE_SELECT = 8'h02;
  localparam logic [7:0] OFF_GUARD_TIME = 8'h0A;
  localparam logic [7:0] OFF_EVENT_FLAGS = 8'h80;
  localparam logic [7:0] OFF_LINE_STATUS = 8'h81;
  localparam logic [7:0] OFF_RECEIVED_BYTE = 8'h82;
  localparam logic [7:0] OFF_SPECIAL_A = 8'hF1;
  localparam logic [7:0] OFF_SPECIAL_B = 8'hF5;

  // implemented bits per register, others read zero
  localparam logic [7:0] MASK_TONE_SELECT = 8'h8F;
  localparam logic [7:0] MASK_GUARD_TIME = 8'h7F;
  localparam logic [7:0] MASK_SPECIAL = 8'h3F;

  // field positions
  localparam int TONE_ON_BIT = 7;
  localparam int EV_MARK_BIT = 6;
  localparam int EV_PROGRESS_BIT = 5;
  localparam int EV_FRAME_BIT = 2;
  localparam int EV_ALERT_BIT = 1;
  localparam int EV_REVERSAL_BIT = 0;
  localparam int ST_PROGRESS_BIT = 5;
  localparam int ST_ALERT_BIT = 1;
  localparam int ST_REVERSAL_BIT = 0;

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic RST_REVERSAL_STATUS = 1'b1;

  // serial bit counting
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ALL = 4'h8;

  // guard time unit and clock
  localparam int CLK_PERIOD_NS = 10;
  localparam int GUARD_UNIT_NS = 1000000;
  localparam int GUARD_TICK_DEFAULT = GUARD_UNIT_NS / CLK_PERIOD_NS;

  // serial engine states, gray along the write path
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ADDR_ACK = 4'h3,
    ST_REG = 4'h2,
    ST_REG_ACK = 4'h6,
    ST_WR = 4'h7,
    ST_WR_ACK = 4'h5,
    ST_RD = 4'h4,
    ST_RD_ACK = 4'hC
  } cid_state_e;

endpackage

/* rtl/cid_sync.sv */
`timescale 1ns/1ps
module cid_sync #(
  parameter int W = 2
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_q;

  // two stages; the first is read by the second only
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      meta_q <= '1;
      q_o <= '1;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end

endmodule

/* rtl/cid_regbank.sv */
`timescale 1ns/1ps
module cid_regbank
  import cid_pkg::*;
#(
  parameter int GUARD_TICK_CYCLES = GUARD_TICK_DEFAULT
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_b_o,
  input wire logic mark_start_seen_i,
  input wire logic progress_tone_present_i,
  input wire logic alert_tone_present_i,
  input wire logic frame_done_i,
  input wire logic [7:0] frame_byte_i,
  input wire logic reversal_seen_i,
  input wire logic signed [7:0] tone_sample_i,
  output logic tone_enable_o,
  output logic [3:0] tone_code_o,
  output logic signed [15:0] tone_out_o,
  output logic irq_b_o
);

  localparam int TICK_W = $clog2(GUARD_TICK_CYCLES);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(GUARD_TICK_CYCLES - 1);

  // prescaler needs at least one counter bit
  if (GUARD_TICK_CYCLES < 2) begin : g_chk
    $error("GUARD_TICK_CYCLES must be at least 2");
  end

  ////////////////////////////////////////////////////////////////////////
  // pin sampling and bus conditions

  logic [1:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic scl_prev_q;
  logic sda_prev_q;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  cid_sync #(
    .W(2)
  ) u_sync (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .d_i({scl_i, sda_i}),
    .q_o(pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // previous samples for edge finding
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  // start and stop are data edges while the clock is high
  assign scl_rise = scl_s && !scl_prev_q;
  assign scl_fall = !scl_s && scl_prev_q;
  assign start_det = scl_s && scl_prev_q && sda_prev_q && !sda_s;
  assign stop_det = scl_s && scl_prev_q && !sda_prev_q && sda_s;

  ////////////////////////////////////////////////////////////////////////
  // register storage

  cid_state_e state_q;
  logic [7:0] reg_addr_q;
  logic [7:0] tone_gain_q;
  logic [7:0] tone_select_q;
  logic [7:0] guard_time_q;
  logic [7:0] special_a_q;
  logic [7:0] special_b_q;
  logic [7:0] event_flags_q;
  logic [7:0] received_byte_q;
  logic progress_q;
  logic alert_q;
  logic reversal_status_q;
  logic [7:0] shift_q;
  logic byte_done_q;
  logic rw_q;
  logic more_q;
  logic wr_fire;
  logic rd_load;
  logic [7:0] rd_byte;
  logic [7:0] line_status;

  assign line_status = {2'b00, progress_q, 3'b000, alert_q, reversal_status_q};

  // read mux; unmapped offsets answer zero
  always_comb begin
    unique case (reg_addr_q) // RULE15 RULE16 RULE22
      OFF_TONE_GAIN: rd_byte = tone_gain_q;
      OFF_TONE_SELECT: rd_byte = tone_select_q;
      OFF_GUARD_TIME: rd_byte = guard_time_q;
      OFF_EVENT_FLAGS: rd_byte = event_flags_q;
      OFF_LINE_STATUS: rd_byte = line_status;
      OFF_RECEIVED_BYTE: rd_byte = received_byte_q;
      OFF_SPECIAL_A: rd_byte = special_a_q;
      OFF_SPECIAL_B: rd_byte = special_b_q;
      default: rd_byte = RST_BYTE;
    endcase
  end

  // a completed write byte; start or stop in that cycle wins
  assign wr_fire = scl_fall && !start_det && !stop_det && state_q == ST_WR && byte_done_q;

  // a byte is handed to the shifter, first after address or after host ack
  assign rd_load = scl_fall && !start_det && !stop_det
    && ((state_q == ST_ADDR_ACK && rw_q) || (state_q == ST_RD_ACK && more_q));

  // writable registers; read-only offsets fall through untouched
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      tone_gain_q <= RST_BYTE;
      tone_select_q <= RST_BYTE;
      guard_time_q <= RST_BYTE;
      special_a_q <= RST_BYTE;
      special_b_q <= RST_BYTE;
    end else if (wr_fire) begin
      unique case (reg_addr_q) // RULE15 RULE21
        OFF_TONE_GAIN: tone_gain_q <= shift_q;
        OFF_TONE_SELECT: tone_select_q <= shift_q & MASK_TONE_SELECT;
        OFF_GUARD_TIME: guard_time_q <= shift_q & MASK_GUARD_TIME; // RULE3
        OFF_SPECIAL_A: special_a_q <= shift_q & MASK_SPECIAL;
        OFF_SPECIAL_B: special_b_q <= shift_q & MASK_SPECIAL;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // serial engine

  logic [3:0] bit_cnt_q;
  logic sda_oe_b_q;

  // bytes in on clock rise, our bits change on clock fall
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= '0;
      byte_done_q <= 1'b0;
      shift_q <= RST_BYTE;
      reg_addr_q <= RST_BYTE;
      rw_q <= 1'b0;
      more_q <= 1'b0;
      sda_oe_b_q <= 1'b1;
    end else if (start_det) begin
      // repeated start keeps the stored register address
      state_q <= ST_ADDR;
      bit_cnt_q <= '0;
      byte_done_q <= 1'b0;
      sda_oe_b_q <= 1'b1;
    end else if (stop_det) begin
      state_q <= ST_IDLE;
      sda_oe_b_q <= 1'b1;
    end else if (scl_rise) begin
      if (state_q == ST_ADDR || state_q == ST_REG || state_q == ST_WR) begin
        shift_q <= {shift_q[6:0], sda_s};
        bit_cnt_q <= 4'(bit_cnt_q + 4'h1);
        byte_done_q <= (bit_cnt_q == BIT_LAST);
      end else if (state_q == ST_RD) begin
        bit_cnt_q <= 4'(bit_cnt_q + 4'h1);
      end else if (state_q == ST_RD_ACK) begin
        // host ack low asks for the next register
        more_q <= !sda_s;
        if (!sda_s) begin
          reg_addr_q <= 8'(reg_addr_q + 8'h01); // RULE18
        end
      end
    end else if (scl_fall) begin
      unique case (state_q)
        ST_IDLE: ;
        ST_ADDR: begin
          if (byte_done_q) begin
            byte_done_q <= 1'b0;
            bit_cnt_q <= '0;
            if (shift_q[7:1] == DEV_ADDR) begin // RULE17
              rw_q <= shift_q[0];
              sda_oe_b_q <= 1'b0;
              state_q <= ST_ADDR_ACK;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (rw_q) begin
            shift_q <= rd_byte;
            sda_oe_b_q <= rd_byte[7];
            state_q <= ST_RD;
          end else begin
            sda_oe_b_q <= 1'b1;
            state_q <= ST_REG;
          end
        end
        ST_REG: begin
          if (byte_done_q) begin
            byte_done_q <= 1'b0;
            bit_cnt_q <= '0;
            reg_addr_q <= shift_q; // RULE18
            sda_oe_b_q <= 1'b0;
            state_q <= ST_REG_ACK;
          end
        end
        ST_REG_ACK: begin
          sda_oe_b_q <= 1'b1;
          state_q <= ST_WR;
        end
        ST_WR: begin
          if (byte_done_q) begin
            byte_done_q <= 1'b0;
            bit_cnt_q <= '0;
            sda_oe_b_q <= 1'b0;
            state_q <= ST_WR_ACK;
          end
        end
        ST_WR_ACK: begin
          sda_oe_b_q <= 1'b1;
          reg_addr_q <= 8'(reg_addr_q + 8'h01); // RULE18
          state_q <= ST_WR;
        end
        ST_RD: begin
          if (bit_cnt_q == BIT_ALL) begin
            // let go so the host can answer
            sda_oe_b_q <= 1'b1;
            bit_cnt_q <= '0;
            state_q <= ST_RD_ACK;
          end else begin
            shift_q <= {shift_q[6:0], 1'b1};
            sda_oe_b_q <= shift_q[6];
          end
        end
        ST_RD_ACK: begin
          if (more_q) begin
            shift_q <= rd_byte;
            sda_oe_b_q <= rd_byte[7];
            state_q <= ST_RD;
          end else begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // open drain: only ever pull low, enable low drives
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
    end
  end

  assign sda_oe_b_o = sda_oe_b_q;

  ////////////////////////////////////////////////////////////////////////
  // reversal guard timer

  logic [TICK_W-1:0] tick_q;
  logic [6:0] unit_q;
  logic guard_run_q;
  logic guard_expire;
  logic reversal_next;

  // expiry once one more than the guard count of units has passed
  assign guard_expire = guard_run_q && tick_q == TICK_LAST && unit_q >= guard_time_q[6:0]; // RULE3
  assign reversal_next = reversal_seen_i ? 1'b0 : (guard_expire ? 1'b1 : reversal_status_q);

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      tick_q <= '0;
      unit_q <= '0;
      guard_run_q <= 1'b0;
      reversal_status_q <= RST_REVERSAL_STATUS; // RULE11
    end else begin
      reversal_status_q <= reversal_next; // RULE11
      if (reversal_seen_i) begin
        // a fresh event restarts the whole guard window
        tick_q <= '0;
        unit_q <= '0;
        guard_run_q <= 1'b1;
      end else if (guard_run_q) begin
        if (tick_q == TICK_LAST) begin
          tick_q <= '0;
          unit_q <= 7'(unit_q + 7'h01);
          guard_run_q <= !guard_expire;
        end else begin
          tick_q <= TICK_W'(tick_q + 1'b1);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // detector status and events

  logic [7:0] event_set;

  always_comb begin
    event_set = RST_BYTE;
    event_set[EV_MARK_BIT] = mark_start_seen_i; // RULE4
    event_set[EV_PROGRESS_BIT] = progress_tone_present_i != progress_q; // RULE5
    event_set[EV_FRAME_BIT] = frame_done_i; // RULE6
    event_set[EV_ALERT_BIT] = alert_tone_present_i && !alert_q; // RULE7
    event_set[EV_REVERSAL_BIT] = reversal_next != reversal_status_q; // RULE8
  end

  // a set in the clearing cycle survives the read
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      event_flags_q <= RST_BYTE;
    end else if (rd_load && reg_addr_q == OFF_EVENT_FLAGS) begin
      event_flags_q <= event_set; // RULE19
    end else begin
      event_flags_q <= event_flags_q | event_set;
    end
  end

  // detector levels are on this clock, no sampling stages
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      progress_q <= 1'b0;
      alert_q <= 1'b0;
    end else begin
      progress_q <= progress_tone_present_i; // RULE9
      alert_q <= alert_tone_present_i; // RULE10
    end
  end

  // last frame byte
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      received_byte_q <= RST_BYTE;
    end else if (frame_done_i) begin
      received_byte_q <= frame_byte_i; // RULE12
    end
  end

  // interrupt is a level, low for as long as a flag stands
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      irq_b_o <= 1'b1;
    end else begin
      irq_b_o <= ~|event_flags_q; // RULE20
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // tone outputs

  logic signed [16:0] tone_prod;

  assign tone_prod = tone_sample_i * $signed({1'b0, tone_gain_q}); // RULE13

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      tone_enable_o <= 1'b0;
      tone_code_o <= '0;
      tone_out_o <= '0;
    end else begin
      tone_enable_o <= tone_select_q[TONE_ON_BIT]; // RULE1
      tone_code_o <= tone_select_q[3:0]; // RULE2
      // silenced rather than gated downstream
      tone_out_o <= tone_select_q[TONE_ON_BIT] ? tone_prod[15:0] : '0; // RULE1 RULE13
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  a_tone_silent: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RULE1
    !tone_select_q[TONE_ON_BIT] |=> tone_out_o == '0)
    else $error("tone output not silent while disabled");

  a_gain_mult: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RULE13
    tone_select_q[TONE_ON_BIT] |=> tone_out_o
      == 16'($past(tone_sample_i) * $signed({1'b0, $past(tone_gain_q)})))
    else $error("tone output not scaled by gain");

  a_mark_flag: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RULE4
    mark_start_seen_i |=> event_flags_q[EV_MARK_BIT])
    else $error("mark start not flagged");

  a_progress_flag: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RULE5
    $changed(progress_q) |-> event_flags_q[EV_PROGRESS_BIT])
    else $error("progress change not flagged");

  a_frame_byte: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RULE6
    frame_done_i |=> event_flags_q[EV_FRAME_BIT] && received_byte_q == $past(frame_byte_i))
    else $error("frame not flagged or byte not kept");

  a_reversal_flag: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RULE8
    $changed(reversal_status_q) |-> event_flags_q[EV_REVERSAL_BIT])
    else $error("reversal status change not flagged");

  a_reversal_low: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RULE11
    reversal_seen_i |=> !reversal_status_q ##1 !reversal_status_q)
    else $error("reversal status not cleared by event");

  a_irq_level: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RULE20
    (|event_flags_q) ##1 (|event_flags_q) |-> !irq_b_o)
    else $error("interrupt not low with flags set");

  a_addr_ack: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RULE17
    state_q == ST_ADDR_ACK && $changed(state_q) |-> shift_q[7:1] == DEV_ADDR && !sda_oe_b_q)
    else $error("acknowledged a foreign address");

endmodule

/* test/cid_host_model.sv */
`timescale 1ns/1ps
// two-wire host: drives the serial clock, only ever pulls data low
module cid_host_model (
  input wire logic dev_sda_i,
  input wire logic dev_sda_oe_b_i,
  output logic scl_o,
  output logic sda_line_o,
  output logic rd_done_o,
  output logic [7:0] rd_byte_o
);
  // quarter of the 125 ns serial period
  localparam realtime QTR = 31.25;
  logic host_sda = 1'b1;

  // wired-and with pull-up, an undriven device counts as released
  assign sda_line_o = host_sda & ~(dev_sda_oe_b_i === 1'b0 && dev_sda_i !== 1'b1);

  initial begin
    scl_o = 1'b1;
    rd_done_o = 1'b0;
    rd_byte_o = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////
  // data moves only while the clock is low, sampled mid-high
  task automatic bit_x(input logic b, output logic r);
    #QTR host_sda = b;
    #QTR scl_o = 1'b1;
    #QTR r = sda_line_o;
    #QTR scl_o = 1'b0;
  endtask

  // start and repeated start share one shape; clock left low
  task automatic start_c();
    #QTR host_sda = 1'b1;
    #QTR scl_o = 1'b1;
    #QTR host_sda = 1'b0;
    #QTR scl_o = 1'b0;
  endtask

  // clock stands high after the stop, outside frames
  task automatic stop_c();
    #QTR host_sda = 1'b0;
    #QTR scl_o = 1'b1;
    #QTR host_sda = 1'b1;
    #QTR;
  endtask

  task automatic send_byte(input logic [7:0] d, inout logic ok);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ok = ok & ~r;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // write n bytes, first byte in the top of d
  task automatic wr(input logic [7:0] dev, input logic [7:0] reg_a, input logic [23:0] d,
                    input int n, output logic ok);
    ok = 1'b1;
    start_c();
    send_byte(dev, ok);
    send_byte(reg_a, ok);
    for (int k = 0; k < n; k++) send_byte(d[23-8*k -: 8], ok);
    stop_c();
  endtask

  // read n bytes, ack all but the last; address phase optional
  task automatic rd(input logic use_reg, input logic [7:0] reg_a, input int n,
                    output logic ok);
    logic r;
    logic [7:0] v;
    ok = 1'b1;
    if (use_reg) begin
      start_c();
      send_byte(8'h30, ok);
      send_byte(reg_a, ok);
    end
    start_c();
    send_byte(8'h31, ok);
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) begin
        bit_x(1'b1, r);
        v[i] = r;
      end
      rd_byte_o = v;
      rd_done_o = 1'b1;
      bit_x(k == n - 1, r);
      rd_done_o = 1'b0;
    end
    stop_c();
  endtask
endmodule

/* test/cid_regbank_tb.sv */
`timescale 1ns/1ps
module cid_regbank_tb;
  // short guard unit keeps the expiry run brief
  localparam int TICK = 8;
  logic clk = 1'b0, rst_b = 1'b0, mark = 1'b0, prog = 1'b0, alert = 1'b0;
  logic frame_done = 1'b0, rev = 1'b0;
  logic [7:0] frame_byte = 8'h00;
  logic signed [7:0] sample = 8'sh00;
  logic scl, sda_line, sda_o, sda_oe_b, tone_en, irq_b, rd_done;
  logic [3:0] tone_code;
  logic signed [15:0] tone_out;
  logic [7:0] rd_byte;
  logic [7:0] exp_q[$];
  int failures = 0;
  int n_tests = 0;

  always #5 clk = ~clk;

  cid_regbank #(.GUARD_TICK_CYCLES(TICK)) cid_regbank_inst (
    .clock_i(clk), .rst_b_i(rst_b), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe_b_o(sda_oe_b), .mark_start_seen_i(mark), .progress_tone_present_i(prog),
    .alert_tone_present_i(alert), .frame_done_i(frame_done), .frame_byte_i(frame_byte),
    .reversal_seen_i(rev), .tone_sample_i(sample), .tone_enable_o(tone_en),
    .tone_code_o(tone_code), .tone_out_o(tone_out), .irq_b_o(irq_b));

  cid_host_model cid_host_model_inst (
    .dev_sda_i(sda_o), .dev_sda_oe_b_i(sda_oe_b), .scl_o(scl), .sda_line_o(sda_line),
    .rd_done_o(rd_done), .rd_byte_o(rd_byte));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // inputs move 1 ns after the edge, clear of sampling
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // note the expected bytes, then let the host read them
  task automatic rd_chk(input logic use_reg, input logic [7:0] a, input logic [23:0] e,
                        input int n);
    logic ok;
    for (int k = 0; k < n; k++) exp_q.push_back(e[23-8*k -: 8]);
    cid_host_model_inst.rd(use_reg, a, n, ok);
    check("read_ack", {15'h0, ok}, 16'h0001);
  endtask

  task automatic wr_chk(input logic [7:0] dev, input logic [7:0] a, input logic [23:0] d,
                        input int n);
    logic ok;
    cid_host_model_inst.wr(dev, a, d, n, ok);
    check("write_ack", {15'h0, ok}, {15'h0, dev == 8'h30});
  endtask

  // each byte the host reads is matched to the oldest note
  always @(posedge rd_done) begin
    if (exp_q.size() == 0) check("read_extra", {8'h00, rd_byte}, 16'hFFFF);
    else check("read_byte", {8'h00, rd_byte}, {8'h00, exp_q.pop_front()});
  end

  // hang guard
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] g, s, gt, fb;
    void'($urandom(76330));
    g = 8'($urandom());
    s = 8'($urandom()) | 8'h80;
    gt = 8'($urandom());
    fb = 8'($urandom());
    sample = 8'($urandom());
    tick(2);
    rst_b = 1'b1;
    tick(10);
    check("irq_idle", {15'h0, irq_b}, 16'h0001);
    rd_chk(1'b1, 8'h80, 24'h000100, 2);
    // registers, auto-increment across an unmapped hole, foreign address
    wr_chk(8'h30, 8'h00, {g, 8'hFF, s}, 3);
    wr_chk(8'h32, 8'h02, 24'hFF0000, 1);
    wr_chk(8'h30, 8'h0A, {gt, 16'h0000}, 1);
    rd_chk(1'b1, 8'h00, {g, 8'h00, s & 8'h8F}, 3);
    rd_chk(1'b1, 8'h0A, {gt & 8'h7F, 16'h0000}, 1);
    tick(3);
    check("tone_en", {15'h0, tone_en}, 16'h0001);
    check("tone_code", {12'h0, tone_code}, {12'h0, s[3:0]});
    check("tone_out", tone_out, 16'(int'(sample) * int'(g)));
    wr_chk(8'h30, 8'h02, 24'h050000, 1);
    tick(3);
    check("tone_off", {tone_en, 11'h0, tone_code}, 16'h0005);
    check("tone_mute", tone_out, 16'h0000);
    // fixed patterns, then address wrap and read from the last address
    wr_chk(8'h30, 8'hF1, 24'h070000, 1);
    wr_chk(8'h30, 8'hF5, 24'h000000, 1);
    rd_chk(1'b1, 8'hF1, 24'h070000, 1);
    rd_chk(1'b1, 8'hFF, {8'h00, g, 8'h00}, 2);
    rd_chk(1'b0, 8'h00, {g, 16'h0000}, 1);
    // mark, progress, alert and frame events at once, writes to read-only places ignored
    prog = 1'b1;
    alert = 1'b1;
    mark = 1'b1;
    frame_done = 1'b1;
    frame_byte = fb;
    tick(1);
    mark = 1'b0;
    frame_done = 1'b0;
    frame_byte = ~fb;
    tick(3);
    check("irq_set", {15'h0, irq_b}, 16'h0000);
    wr_chk(8'h30, 8'h80, 24'hFFFFFF, 3);
    rd_chk(1'b1, 8'h80, {8'h66, 8'h23, fb}, 3);
    check("irq_clear", {15'h0, irq_b}, 16'h0001);
    // falling levels: progress flags again, alert does not
    prog = 1'b0;
    alert = 1'b0;
    tick(3);
    rd_chk(1'b1, 8'h80, 24'h200100, 2);
    // reversal inside and after the longest guard time
    wr_chk(8'h30, 8'h0A, 24'hFF0000, 1);
    rev = 1'b1;
    tick(1);
    rev = 1'b0;
    rd_chk(1'b1, 8'h80, 24'h010000, 2);
    tick(1000);
    rd_chk(1'b1, 8'h80, 24'h010100, 2);
    // reset mid-run with the reversal status low and a flag pending
    rev = 1'b1;
    tick(1);
    rev = 1'b0;
    tick(2);
    check("irq_rev", {15'h0, irq_b}, 16'h0000);
    rst_b = 1'b0;
    tick(2);
    rst_b = 1'b1;
    tick(1);
    check("irq_reset", {15'h0, irq_b}, 16'h0001);
    check("tone_reset", {tone_en, 11'h0, tone_code}, 16'h0000);
    tick(10);
    rd_chk(1'b1, 8'h80, 24'h000100, 2);
    check("pending", 16'(exp_q.size()), 16'h0000);
    report_and_stop();
  end
endmodule
